// *** fwlc_flash_control.v ***
// top: address latch, read latency, embedded program/erase with suspend
`timescale 1ns/1ps
`include "fwlc_consts.vh"
module fwlc_flash_control #(
  parameter SUSPEND_LAT_CYC = `FWLC_SUSPEND_LAT_CYC,
  parameter OP_STEP_CYC     = 16
) (
  input  wire        ref_clk,
  input  wire        reset_n,
  input  wire        chip_enable_n,
  input  wire        address_valid_strobe_n,
  input  wire        write_enable_n,
  input  wire        output_enable_n,
  input  wire        strobe_tied_mode,
  input  wire [3:0]  initial_wait_count,
  input  wire        ready_timing_select,
  input  wire [7:0]  address,
  input  wire [15:0] data_in,
  input  wire [3:0]  command,
  output reg  [15:0] data_out,
  output reg         data_oe,
  output reg         ready,
  output reg  [7:0]  latchedAddress,
  output reg         addressStrobe,
  output reg  [7:0]  status,
  output reg         bufferFull
);
  localparam S_IDLE = 3'h0, S_PREPROG = 3'h1, S_ERASE = 3'h2, S_PROG = 3'h3,
             S_SUSP = 3'h4, S_DONE = 3'h5;

  // two-flop synchronisers for pins
  reg [1:0] ceSync, avSync, weSync, oeSync;
  reg       avPrev, wePrev;
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      ceSync <= 2'h3;
      avSync <= 2'h3;
      weSync <= 2'h3;
      oeSync <= 2'h3;
      avPrev <= 1'b1;
      wePrev <= 1'b1;
    end else begin
      ceSync <= {ceSync[0], chip_enable_n};
      avSync <= {avSync[0], address_valid_strobe_n};
      weSync <= {weSync[0], write_enable_n};
      oeSync <= {oeSync[0], output_enable_n};
      avPrev <= avSync[1];
      wePrev <= weSync[1];
    end
  end
  wire ceOn   = !ceSync[1];
  wire avRise = !avPrev && avSync[1];
  wire weFall = wePrev && !weSync[1];
  wire weRise = !wePrev && weSync[1];
  // address pins sampled twice like the strobes so they line up
  reg [7:0]  addrS1, addrS2;
  reg [15:0] dinS1, dinS2;
  reg [3:0]  cmdS1, cmdS2;
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      addrS1 <= 8'h00;
      addrS2 <= 8'h00;
      dinS1  <= 16'h0000;
      dinS2  <= 16'h0000;
      cmdS1  <= 4'h0;
      cmdS2  <= 4'h0;
    end else begin
      addrS1 <= address;
      addrS2 <= addrS1;
      dinS1  <= data_in;
      dinS2  <= dinS1;
      cmdS1  <= command;
      cmdS2  <= cmdS1;
    end
  end

  wire latchNow = ceOn && (strobe_tied_mode ? weFall : avRise); // see RL4 // see RL5
  wire readLatch = ceOn && avRise && !strobe_tied_mode && weSync[1];
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      latchedAddress <= 8'h00;
      addressStrobe  <= 1'b0;
    end else begin
      addressStrobe <= latchNow;
      if (latchNow)
        latchedAddress <= addrS2; // see RL4 // see RL5
    end
  end

  // array: upper half one bank, lower half another
  reg [15:0] array [0:255];
  reg [15:0] wbuf  [0:31];
  reg [5:0]  bufCount;
  reg [4:0]  progIdx;
  reg [7:0]  regionBase;
  reg [15:0] regionIdx;
  reg        busyBank;
  reg [2:0]  state, resumeState;
  reg [15:0] stepCnt;
  reg [31:0] suspCnt;
  wire writeCycle = ceOn && weRise;
  wire isWrite = writeCycle && (cmdS2 == 4'h0);
  wire bankOf  = latchedAddress[7];
  wire busy    = (state != S_IDLE) && (state != S_DONE);

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      state       <= S_IDLE;
      resumeState <= S_IDLE;
      bufCount    <= 6'h00;
      progIdx     <= 5'h00;
      regionBase  <= 8'h00;
      regionIdx   <= 16'h0000;
      busyBank    <= 1'b0;
      stepCnt     <= 16'h0000;
      suspCnt     <= 32'h0;
      status      <= 8'h00;
      bufferFull  <= 1'b0;
    end else begin
      bufferFull <= (bufCount == `FWLC_BUF_WORDS); // see RL13
      status[`FWLC_ST_BUSY_BIT] <= busy;
      if (state == S_IDLE || state == S_DONE) begin
        if (isWrite && bufCount < `FWLC_BUF_WORDS) begin
          wbuf[bufCount[4:0]] <= dinS2; // see RL13
          if (bufCount == 6'h00)
            regionBase <= latchedAddress;
          bufCount <= bufCount + 6'h01;
        end else if (writeCycle && cmdS2 == `FWLC_CMD_PROGRAM && bufCount != 6'h00) begin
          state    <= S_PROG;
          progIdx  <= 5'h00;
          busyBank <= regionBase[7];
          status   <= 8'h01;
          stepCnt  <= 16'h0000;
        end else if (writeCycle && cmdS2 == `FWLC_CMD_ERASE) begin
          state      <= S_PREPROG; // see RL9
          regionBase <= {latchedAddress[7:4], 4'h0};
          busyBank   <= latchedAddress[7];
          regionIdx  <= 16'h0000;
          status     <= 8'h01;
          stepCnt    <= 16'h0000;
        end
      end else if (state == S_SUSP) begin
        if (writeCycle && cmdS2 == `FWLC_CMD_RESUME) begin
          state  <= resumeState;
          status[`FWLC_ST_ESUSP_BIT] <= 1'b0;
          status[`FWLC_ST_PSUSP_BIT] <= 1'b0;
        end
      end else begin
        if (writeCycle && cmdS2 == `FWLC_CMD_SUSPEND) begin
          resumeState <= state;
          suspCnt     <= 32'h0;
        end
        // suspension taken at the next step boundary, which is far below the limit
        if (suspCnt != 32'h0 || (writeCycle && cmdS2 == `FWLC_CMD_SUSPEND))
          suspCnt <= suspCnt + 32'h1;
        if (suspCnt != 32'h0 &&
            (stepCnt == OP_STEP_CYC[15:0] - 16'h1 || suspCnt >= SUSPEND_LAT_CYC - 1)) begin
          state   <= S_SUSP; // see RL6
          suspCnt <= 32'h0;
          if (resumeState == S_PROG)
            status[`FWLC_ST_PSUSP_BIT] <= 1'b1;
          else
            status[`FWLC_ST_ESUSP_BIT] <= 1'b1;
        end else if (stepCnt != OP_STEP_CYC[15:0] - 16'h1) begin
          stepCnt <= stepCnt + 16'h1;
        end else begin
          stepCnt <= 16'h0000;
          case (state)
            S_PREPROG: begin
              array[regionBase + regionIdx[7:0]] <= `FWLC_PREPROG_WORD; // see RL9
              if (regionIdx == `FWLC_REGION_WORDS - 16'h1) begin
                regionIdx <= 16'h0000;
                state     <= S_ERASE;
              end else
                regionIdx <= regionIdx + 16'h1;
            end
            S_ERASE: begin
              array[regionBase + regionIdx[7:0]] <= `FWLC_ERASED_WORD;
              if (regionIdx == `FWLC_REGION_WORDS - 16'h1) begin
                state  <= S_DONE;
                status <= 8'h80; // see RL10
              end else
                regionIdx <= regionIdx + 16'h1;
            end
            S_PROG: begin
              array[regionBase + {3'h0, progIdx}] <= wbuf[progIdx]; // see RL13
              if ({1'b0, progIdx} == bufCount - 6'h01) begin
                state    <= S_DONE;
                bufCount <= 6'h00;
                status   <= 8'h80;
              end else
                progIdx <= progIdx + 5'h01;
            end
            default: state <= S_IDLE;
          endcase
        end
      end
    end
  end

  wire dataValid, readyEarly;
  fwlc_wait_counter waitCounter (
    .ref_clk             (ref_clk),
    .reset_n             (reset_n),
    .start               (readLatch),
    .initial_wait_count  (initial_wait_count),
    .ready_timing_select (ready_timing_select),
    .dataValid           (dataValid),
    .readyEarly          (readyEarly),
    .codeReserved        ()
  );

  // busy bank answers with status; the other bank serves array data
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      data_out <= 16'h0000;
      data_oe  <= 1'b0;
      ready    <= 1'b0;
    end else begin
      data_oe <= ceOn && !oeSync[1];
      ready   <= ready_timing_select ? dataValid : readyEarly; // see RL2 // see RL3
      if (dataValid || (strobe_tied_mode && ceOn)) begin
        if ((busy || state == S_SUSP) && bankOf == busyBank)
          data_out <= {8'h00, status}; // see RL10 // see RL11
        else
          data_out <= array[latchedAddress]; // see RL11
      end
    end
  end
endmodule // fwlc_flash_control

// *** fwlc_consts.vh ***
// constants for the flash write-sequencing and read-latency control block
// What this block does and what its host must do
// RL1: wait code selects first data edge, three upward
// RL2: ready bit set: ready with data
// RL3: ready bit clear: ready one cycle early
// RL4: strobe-toggled mode: address on strobe rising
// RL5: strobe-tied mode: address on write falling
// RL6: suspended state reached within 30 us
// RL7: host waits 30 us resume to erase-suspend
// RL8: host waits 30 us resume to program-suspend
// RL9: erase pre-programs every word to zero first
// RL10: erase completion shown in status for polling
// RL11: serve other-bank reads during busy bank
// RL12: host does two status reads before next
// RL13: buffer program takes up to 32 words
// RL14: host sizes suspend intervals by own clock
`ifndef FWLC_CONSTS_VH
`define FWLC_CONSTS_VH
`define FWLC_CLK_PERIOD_PS   4000
`define FWLC_SUSPEND_LAT_US  30
`define FWLC_SUSPEND_LAT_CYC ((`FWLC_SUSPEND_LAT_US * 1000000) / `FWLC_CLK_PERIOD_PS)
`define FWLC_WAIT_MIN_CODE   4'h1
`define FWLC_WAIT_MAX_CODE   4'hb
`define FWLC_WAIT_EDGE_BASE  4'h2
`define FWLC_BUF_WORDS       6'h20
`define FWLC_PREPROG_WORD    16'h0000
`define FWLC_ERASED_WORD     16'hffff
`define FWLC_REGION_WORDS    16'h0010
`define FWLC_ST_DONE_BIT     7
`define FWLC_ST_ESUSP_BIT    6
`define FWLC_ST_PSUSP_BIT    2
`define FWLC_ST_BUSY_BIT     0
`define FWLC_CMD_ERASE       4'h1
`define FWLC_CMD_PROGRAM     4'h2
`define FWLC_CMD_SUSPEND     4'h3
`define FWLC_CMD_RESUME      4'h4
`endif

// *** fwlc_wait_counter.v ***
// first-data and ready timing for a synchronous read
`timescale 1ns/1ps
`include "fwlc_consts.vh"
module fwlc_wait_counter (
  input  wire       ref_clk,
  input  wire       reset_n,
  input  wire       start,
  input  wire [3:0] initial_wait_count,
  input  wire       ready_timing_select,
  output reg        dataValid,
  output reg        readyEarly,
  output reg        codeReserved
);
  reg [3:0] count;
  reg       running;
  wire      codeOk = (initial_wait_count >= `FWLC_WAIT_MIN_CODE) &&
                     (initial_wait_count <= `FWLC_WAIT_MAX_CODE);
  // edge n+2 after latch for code n; start is the latch edge itself
  wire [3:0] target = initial_wait_count + `FWLC_WAIT_EDGE_BASE; // see RL1
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      count        <= 4'h0;
      running      <= 1'b0;
      dataValid    <= 1'b0;
      readyEarly   <= 1'b0;
      codeReserved <= 1'b0;
    end else begin
      codeReserved <= !codeOk;
      if (start && codeOk) begin
        running    <= 1'b1;
        count      <= 4'h1;
        dataValid  <= 1'b0;
        readyEarly <= (target == 4'h2) && !ready_timing_select; // see RL3
      end else if (running) begin
        count      <= count + 4'h1;
        dataValid  <= (count + 4'h1 == target); // see RL1
        readyEarly <= (count + 4'h2 == target) && !ready_timing_select; // see RL3
        if (count + 4'h1 == target)
          running <= 1'b0;
      end else begin
        dataValid  <= 1'b0;
        readyEarly <= 1'b0;
      end
    end
  end
endmodule // fwlc_wait_counter

// *** fwlc_flash_control_chk.sv ***
// timing checks on the flash control ports
`timescale 1ns/1ps
module fwlc_flash_control_chk #(
  parameter SUSPEND_LAT_CYC = 7500
) (
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic       chip_enable_n,
  input wire logic       address_valid_strobe_n,
  input wire logic       write_enable_n,
  input wire logic       output_enable_n,
  input wire logic       strobe_tied_mode,
  input wire logic [3:0] initial_wait_count,
  input wire logic       ready_timing_select,
  input wire logic [7:0] address,
  input wire logic [3:0] command,
  input wire logic       data_oe,
  input wire logic       ready,
  input wire logic [7:0] latchedAddress,
  input wire logic       addressStrobe,
  input wire logic [7:0] status
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [7:0] sinceStrobe;
  logic       pend;
  int         waitN;
  // suspend wait counted here, too long for a delay range
  always @(posedge ref_clk) begin
    sinceStrobe <= addressStrobe ? 8'h00 : (sinceStrobe == 8'hff ? sinceStrobe : sinceStrobe + 8'h01);
    if (!reset_n || status[6] || status[2] || !status[0]) begin
      pend <= 1'b0;
      waitN <= 0;
    end else if (pend) begin
      waitN <= waitN + 1;
    end else if ($rose(write_enable_n) && !chip_enable_n && command == 4'h3) begin
      pend <= 1'b1;
    end
  end
  sequence s_latch;
    ##[2:5] addressStrobe;
  endsequence
  a_strobe_on_rise: assert property ($rose(address_valid_strobe_n) && !chip_enable_n && !strobe_tied_mode |-> s_latch)
    else $error("address strobe rise not latched");
  a_strobe_on_write: assert property ($fell(write_enable_n) && !chip_enable_n && strobe_tied_mode |-> s_latch)
    else $error("write fall not latched");
  a_latch_value: assert property (addressStrobe |-> latchedAddress == address)
    else $error("wrong latched address");
  a_strobe_pulse: assert property (addressStrobe |=> !addressStrobe)
    else $error("address strobe longer than one cycle");
  a_ready_edge: assert property (ready |-> sinceStrobe == {4'h0, initial_wait_count} + {7'h00, ready_timing_select})
    else $error("ready on wrong edge");
  a_reserved_quiet: assert property ((initial_wait_count == 4'h0 || initial_wait_count > 4'hb) [*8] |-> !ready)
    else $error("ready with reserved wait code");
  a_oe_follow: assert property ((!chip_enable_n && !output_enable_n) [*4] |-> data_oe)
    else $error("output enable missing");
  a_oe_off: assert property (chip_enable_n [*4] |-> !data_oe)
    else $error("output enable while deselected");
  a_suspend_latency: assert property (waitN <= SUSPEND_LAT_CYC + 4)
    else $error("suspend too slow");
  a_done_idle: assert property ($rose(status[7]) |-> !status[0])
    else $error("done while busy");
endmodule // fwlc_flash_control_chk

// *** fwlc_host_model.sv ***
// host memory controller model driving the flash pins
`timescale 1ns/1ps
module fwlc_host_model (
  input  wire logic        ref_clk,
  input  wire logic        strobe_tied_mode,
  output logic             chip_enable_n,
  output logic             address_valid_strobe_n,
  output logic             write_enable_n,
  output logic             output_enable_n,
  output logic [7:0]       address,
  output logic [15:0]      data_in,
  output logic [3:0]       command
);
  initial begin
    {chip_enable_n, address_valid_strobe_n, write_enable_n, output_enable_n} = 4'hf;
    address = 8'h00;
    data_in = 16'h0000;
    command = 4'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // released address and data lines show the inverse; command keeps its last value
  task automatic release_bus;
    {chip_enable_n, address_valid_strobe_n, output_enable_n} = 3'h7;
    address = ~address;
    data_in = ~data_in;
  endtask
  task automatic select(input logic [7:0] a);
    address = a;
    chip_enable_n = 1'b0;
    address_valid_strobe_n = 1'b0;
    tick(4);
    if (!strobe_tied_mode) address_valid_strobe_n = 1'b1;
  endtask
  task automatic write(input logic [7:0] a, input logic [15:0] d, input logic [3:0] c);
    select(a);
    data_in = d;
    command = c;
    write_enable_n = 1'b0;
    tick(4);
    write_enable_n = 1'b1;
    tick(4);
    release_bus();
    tick(2);
  endtask
  task automatic read_start(input logic [7:0] a);
    select(a);
    output_enable_n = 1'b0;
  endtask
  // two reads of the busy bank before any new command
  task automatic status_reads(input logic [7:0] a);
    repeat (2) begin
      read_start(a);
      tick(4);
      release_bus();
      tick(2);
    end
  endtask
endmodule // fwlc_host_model

// *** test_flash_write_and_latency_control.sv ***
// self-checking bench for the flash control block
`timescale 1ns/1ps
module test_flash_write_and_latency_control;
  logic ref_clk, reset_n, strobe_tied_mode, ready_timing_select;
  logic [3:0]  initial_wait_count;
  wire         ceN, avN, weN, oeN, data_oe, ready, addressStrobe, bufferFull;
  wire  [7:0]  address, latchedAddress, status;
  wire  [15:0] data_in, data_out;
  wire  [3:0]  command;
  int          err_count, checks_done;
  fwlc_host_model host (.ref_clk, .strobe_tied_mode, .chip_enable_n(ceN), .address_valid_strobe_n(avN),
    .write_enable_n(weN), .output_enable_n(oeN), .address, .data_in, .command);
  // shortened counts keep the run brief
  fwlc_flash_control #(.SUSPEND_LAT_CYC(20), .OP_STEP_CYC(2)) dut (.ref_clk, .reset_n, .chip_enable_n(ceN),
    .address_valid_strobe_n(avN), .write_enable_n(weN), .output_enable_n(oeN), .strobe_tied_mode,
    .initial_wait_count, .ready_timing_select, .address, .data_in, .command, .data_out, .data_oe, .ready,
    .latchedAddress, .addressStrobe, .status, .bufferFull);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic do_read(input logic [7:0] a, output int lat, output logic [15:0] d);
    int n;
    n = 0;
    host.read_start(a);
    while (addressStrobe !== 1'b1 && n < 20) begin @(negedge ref_clk); n++; end
    lat = 0;
    while (ready !== 1'b1 && lat < 20) begin @(negedge ref_clk); lat++; end
    repeat (2) @(negedge ref_clk);
    d = data_out;
    check(data_oe === 1'b1, "data not driven");
    host.tick(1);
    host.release_bus();
    host.tick(4);
  endtask
  task automatic wait_status(input int b, input logic v, input int lim, input string msg);
    int n;
    n = 0;
    while (status[b] !== v && n < lim) begin @(negedge ref_clk); n++; end
    check(status[b] === v, msg);
    host.tick(1);
  endtask
  task automatic suspend_cycle(input int b);
    host.write(8'h10, 16'h0000, 4'h3);
    wait_status(b, 1'b1, 16, "not suspended in time");
    host.write(8'h10, 16'h0000, 4'h4);
    wait_status(b, 1'b0, 8, "still suspended");
    host.tick(20);
  endtask
  task automatic t_latency;
    int lat;
    logic [15:0] d;
    for (int s = 0; s < 2; s++) for (int c = 0; c < 16; c++) begin
      ready_timing_select = s[0];
      initial_wait_count = c[3:0];
      host.tick(2);
      do_read(8'h80, lat, d);
      if (c >= 1 && c <= 11) check(lat == c + 1 + s, "first data edge");
      else check(lat == 20, "data with reserved code");
    end
    initial_wait_count = 4'h2;
    $display("latency test done");
  endtask
  task automatic t_program_erase;
    int lat;
    logic [15:0] d;
    for (int i = 0; i < 33; i++) begin
      strobe_tied_mode = i[0];
      host.write(8'h10 + i[7:0], 16'ha500 + i[15:0], 4'h0);
      check(latchedAddress === 8'h10 + i[7:0], "latched address");
      check(bufferFull === (i >= 31), "buffer full flag");
    end
    strobe_tied_mode = 1'b0;
    host.write(8'h10, 16'h0000, 4'h2);
    wait_status(0, 1'b1, 10, "program not busy");
    do_read(8'h90, lat, d);
    check(lat == 4, "other bank read while busy");
    suspend_cycle(2);
    wait_status(7, 1'b1, 300, "program not done");
    host.status_reads(8'h10);
    do_read(8'h2f, lat, d);
    check(d === 16'ha51f, "last buffer word");
    host.write(8'h10, 16'h0000, 4'h1);
    wait_status(0, 1'b1, 10, "erase not busy");
    suspend_cycle(6);
    wait_status(7, 1'b1, 300, "erase not done");
    host.status_reads(8'h10);
    do_read(8'h15, lat, d);
    check(d === 16'hffff, "erased word");
    do_read(8'h25, lat, d);
    check(d === 16'ha515, "word past region");
    $display("program and erase test done");
  endtask
  // mid-run reset: outputs clear, array keeps its words, reads work again
  task automatic t_reset;
    int lat;
    logic [15:0] d;
    @(posedge ref_clk);
    #1 reset_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check(status === 8'h00 && latchedAddress === 8'h00 && bufferFull === 1'b0 && ready === 1'b0,
      "outputs after reset");
    reset_n = 1'b1;
    host.tick(2);
    do_read(8'h15, lat, d);
    check(lat == 4, "first data edge after reset");
    check(d === 16'hffff, "array word after reset");
    $display("reset test done");
  endtask
  initial begin
    {reset_n, strobe_tied_mode, ready_timing_select} = 3'h0;
    initial_wait_count = 4'h1;
    err_count = 0;
    checks_done = 0;
    repeat (16) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    host.tick(2);
    t_latency();
    t_program_erase();
    t_reset();
    report_and_stop();
  end
  initial begin
    #100000;
    err_count++;
    $display("unexpected at %0t: watchdog", $time);
    report_and_stop();
  end
endmodule // test_flash_write_and_latency_control
bind fwlc_flash_control fwlc_flash_control_chk #(.SUSPEND_LAT_CYC(SUSPEND_LAT_CYC)) chk (.ref_clk, .reset_n,
  .chip_enable_n, .address_valid_strobe_n, .write_enable_n, .output_enable_n, .strobe_tied_mode,
  .initial_wait_count, .ready_timing_select, .address, .command, .data_oe, .ready, .latchedAddress,
  .addressStrobe, .status);
